// ---- sim/lgfv_ser_model.sv ----
/*
 Remote serializer model: forward GPIO frames and raw frame/line windows.
 Assumes its tasks are called just after a rising edge of aclk.
*/
`timescale 1ns/1ps

module lgfv_ser_model (
	input wire logic aclk, // Link clock
	output lgfv_pkg::lgfv_rx_t [1:0] rx // Status toward the hub
);
	// Links locked and passing, windows idle
	initial rx = {2{9'h180}};

	task automatic send_fwd(input int p, input logic [3:0] v);
		rx[p].fwd_gpio <= v;
		rx[p].fwd_frame <= 1'b1;
		@(posedge aclk);
		rx[p].fwd_frame <= 1'b0;
		rx[p].fwd_gpio <= ~v; // Lines carry no stale value outside a frame
		repeat (8) @(posedge aclk);
	endtask

	task automatic frame(input logic [1:0] inv, input int setup, input int lines);
		rx[0].frame_window <= inv[0];
		rx[0].line_window <= inv[1];
		repeat (4) @(posedge aclk);
		rx[0].frame_window <= ~inv[0];
		repeat (setup) @(posedge aclk);
		repeat (lines) begin
			rx[0].line_window <= ~inv[1];
			repeat (8) @(posedge aclk);
			rx[0].line_window <= inv[1];
			repeat (4) @(posedge aclk);
		end
		rx[0].frame_window <= inv[0];
		repeat (4) @(posedge aclk);
	endtask
endmodule

// ---- sim/lgfv_top_props.sv ----
/*
 Port checker for lgfv_top: register bus answers, reset state, slot hold.
 Assumes bind onto lgfv_top, one clock domain, back channel at rate 00.
*/
`timescale 1ns/1ps

module lgfv_top_props (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic s_axi_awvalid, // Aw valid
	input wire logic s_axi_awready, // Aw ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic [1:0] s_axi_bresp, // B response
	input wire logic s_axi_arvalid, // Ar valid
	input wire logic s_axi_arready, // Ar ready
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic [1:0] s_axi_rresp, // R response
	input wire lgfv_pkg::lgfv_tx_t [1:0] tx, // Slots and windows
	input wire logic [6:0] pin_oe, // Driver enables
	input wire logic [6:0] pin_pulldown_en, // Pulldown enables
	input wire logic [6:0] pin_input_en // Input enables
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Reset checks must run while reset is low, so they opt out of the default
	a_reset_pins_idle: assert property (disable iff (1'b0) !aresetn |=>
		pin_oe == 7'h00 && tx == '0) else $error("pins or slots active after reset");
	a_reset_enables: assert property (disable iff (1'b0) !aresetn |=>
		pin_pulldown_en == 7'h7F && pin_input_en == 7'h7F) else $error("enables off after reset");
	// After each change the slot holds for at least 8 cycles, well inside a 30-cycle back frame
	a_slot_hold: assert property ($changed(tx[0].bc_slot) |=>
		$stable(tx[0].bc_slot) [*8]) else $error("slot changed inside a back frame");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp})) else $error("read data dropped");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule

bind lgfv_top lgfv_top_props lgfv_top_props_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
	.tx, .pin_oe, .pin_pulldown_en, .pin_input_en);

// ---- sim/lgfv_top_tb.sv ----
/*
 Self-checking bench for lgfv_top: register bus, pins, forward GPIO,
 back channel slots and frame qualification. Assumes lgfv_ser_model.
*/
`timescale 1ns/1ps
`include "lgfv_map.svh"

module lgfv_top_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	lgfv_pkg::lgfv_rx_t [1:0] rx;
	lgfv_pkg::lgfv_tx_t [1:0] tx;
	logic sensor_sync_pulse, ext_sync_in;
	logic [6:0] pin_in, pin_out, pin_oe, pin_pulldown_en, pin_input_en;
	logic [3:0] fval [4] = '{4'h7, 4'h2, 4'h9, 4'hD};
	logic [3:0] fexp [4] = '{4'h0, 4'h2, 4'h2, 4'hD};
	int n_fail, comparisons, lcnt, fcnt, i;

	lgfv_top lgfv_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx, .tx,
		.sensor_sync_pulse, .ext_sync_in, .pin_in, .pin_out, .pin_oe, .pin_pulldown_en,
		.pin_input_en);
	lgfv_ser_model lgfv_ser_model_inst (.aclk, .rx);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Qualified line and frame cycles, compared as differences across a frame
	always @(posedge aclk) lcnt <= lcnt + 32'(tx[0].line_window);
	always @(posedge aclk) fcnt <= fcnt + 32'(tx[0].frame_window);

	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task wait_ok(input int k);
		if (k >= 100) begin
			chk("bus wait", 32'h0, 32'h1);
			give_verdict;
		end
	endtask

	// Handshakes are judged at the falling edge, where every signal is settled
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [1:0] er = `LGFV_AXI_OKAY);
		int k;
		logic ta, tw, bv, tb;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			tb = bv && s_axi_bready;
			if (tb)
				chk("bresp", 32'(er), 32'(s_axi_bresp));
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tb)
				s_axi_bready <= 1'b0;
			if (tb)
				break;
		end
		wait_ok(k);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
		input logic [1:0] er = `LGFV_AXI_OKAY);
		int k;
		logic ta, rv, tr;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			tr = rv && s_axi_rready;
			if (tr) begin
				chk("rdata", ed, s_axi_rdata);
				chk("rresp", 32'(er), 32'(s_axi_rresp));
			end
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			if (tr)
				s_axi_rready <= 1'b0;
			if (tr)
				break;
		end
		wait_ok(k);
	endtask

	task automatic run(input logic [1:0] inv, input int setup, input int exp);
		int s, f;
		s = lcnt;
		f = fcnt;
		lgfv_ser_model_inst.frame(inv, setup, 2);
		chk("line cycles", 32'(exp), 32'(lcnt - s));
		chk("frame cycles", 32'h18, 32'(fcnt - f));
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{sensor_sync_pulse, ext_sync_in, pin_in, lcnt, fcnt, n_fail, comparisons} = '0;
		s_axi_wstrb = 4'hF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		chk("pin_oe", 32'h0, 32'(pin_oe));
		chk("enables", 32'h3FFF, 32'({pin_pulldown_en, pin_input_en}));
		rd(8'hBC, 32'h80);
		rd(8'h0F, 32'h0);
		rd(8'hBE, 32'h0);
		rd(8'h6E, 32'h0);
		rd(8'h20, 32'h0, `LGFV_AXI_SLVERR);
		$display("test reset done");
		wr(8'h0F, 8'h05);
		wr(8'hBE, 8'h03);
		wr(8'h20, 8'h55, `LGFV_AXI_SLVERR);
		wr(8'h4F, 8'hFF);
		chk("input_en", 32'h7A, 32'(pin_input_en));
		chk("pulldown_en", 32'h7C, 32'(pin_pulldown_en));
		wr(8'h10, 8'h83);
		wr(8'h11, 8'h91);
		sensor_sync_pulse <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("pin_oe", 32'h03, 32'(pin_oe));
		chk("pin_out", 32'h3, 32'(pin_out[1:0]));
		wr(8'h10, 8'h81);
		sensor_sync_pulse <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("pin_out", 32'h0, 32'(pin_out[1:0]));
		$display("test pins done");
		wr(8'h6D, 8'h02);
		wr(8'h4C, 8'h01);
		wr(8'h6D, 8'h03);
		wr(8'h4C, 8'h00);
		wr(8'h12, 8'h2D);
		wr(8'h13, 8'h05);
		for (i = 0; i < 4; i++) begin
			lgfv_ser_model_inst.send_fwd(0, fval[i]);
			rd(8'h4F, {28'h0, fexp[i]});
			chk("pin3", 32'(fexp[i][1]), 32'(pin_out[3]));
		end
		for (i = 0; i < 5; i++) begin
			lgfv_ser_model_inst.send_fwd(1, 4'h8);
			rd(8'h4F, {24'h0, (i == 4) ? 4'h8 : 4'h0, 4'hD});
			chk("pin2", 32'(i == 4), 32'(pin_out[2]));
		end
		wr(8'h6D, 8'h09);
		lgfv_ser_model_inst.send_fwd(0, 4'h6);
		rd(8'h4F, 32'h80);
		$display("test forward done");
		wr(8'h6E, 8'h85);
		wr(8'h6F, 8'h59);
		wr(8'h4C, 8'h01);
		wr(8'h6E, 8'h50);
		wr(8'h4C, 8'h00);
		pin_in <= 7'h10;
		sensor_sync_pulse <= 1'b1;
		ext_sync_in <= 1'b1;
		repeat (64) @(posedge aclk);
		chk("slots0", 32'hF, 32'(tx[0].bc_slot));
		chk("slots1", 32'h2, 32'(tx[1].bc_slot));
		pin_in <= 7'h00;
		ext_sync_in <= 1'b0;
		repeat (64) @(posedge aclk);
		chk("slots0", 32'h2, 32'(tx[0].bc_slot));
		chk("slots1", 32'h0, 32'(tx[1].bc_slot));
		$display("test slots done");
		wr(8'hBC, 8'h04);
		run(2'b00, 10, 16);
		run(2'b00, 2, 8);
		rd(8'h4D, 32'h1);
		wr(8'h4D, 8'h01);
		rd(8'h4D, 32'h0);
		wr(8'h7C, 8'h04);
		run(2'b00, 2, 16);
		wr(8'h7C, 8'h07);
		run(2'b11, 10, 16);
		$display("test frames done");
		give_verdict;
	end
endmodule

// ---- src/lgfv_map.svh ----
/*
 Register indexes, field positions, reset values and timing figures of the
 link GPIO and frame qualification block. Definitions only.
 Assumes a 50 MHz register clock and byte address = 4 x register index.
*/
// Contract
// - Seven local pins, each drivable from forward GPIO.
// - Four forward GPIOs per port, routable anywhere.
// - Reject forward GPIO from older serializer types.
// - Forward update every 1, 2 or 5 frames.
// - Sync pulse or internal status selectable per pin.
// - Pins start as inputs, drivers off.
// - Four back slots per port, any pin.
// - Sample slots once per 30-bit back frame.
// - Internal or external sync placeable on slots.
// - Slot selection in two per-port registers.
// - Per-pin input and pulldown disables, default enabled.
// - Frame and line windows give approximate boundaries.
// - Raw mode: frame is vsync, line hsync.
// - Per-port independent frame and line polarity.
// - Frame valid only after programmed minimum setup; the code flags a short setup as a violation and still passes the frame window.
// - Short setup drops first line, option forwards.
// - Device group drives constant programmed level.
`ifndef LGFV_MAP_SVH
`define LGFV_MAP_SVH

`define LGFV_NPINS 7
`define LGFV_NPORTS 2
`define LGFV_IDX_IN_DIS 8'h0F
`define LGFV_IDX_PIN0 8'h10
`define LGFV_IDX_PIN_LAST 8'h16
`define LGFV_IDX_PAGE 8'h4C
`define LGFV_IDX_STATUS 8'h4D
`define LGFV_IDX_LEVEL 8'h4E
`define LGFV_IDX_FWD 8'h4F
`define LGFV_IDX_LINK 8'h6D
`define LGFV_IDX_SLOT_A 8'h6E
`define LGFV_IDX_SLOT_B 8'h6F
`define LGFV_IDX_POL 8'h7C
`define LGFV_IDX_MIN 8'hBC
`define LGFV_IDX_PD_DIS 8'hBE
`define LGFV_REG_RST 8'h00
`define LGFV_MIN_RST 8'h80
`define LGFV_PC_OE 0
`define LGFV_PC_VAL 1
`define LGFV_PC_SEL 4:2
`define LGFV_PC_GRP 7:5
`define LGFV_GRP_PORT0 3'h0
`define LGFV_GRP_PORT1 3'h1
`define LGFV_GRP_DEV 3'h4
`define LGFV_SLOT_LO 3:0
`define LGFV_SLOT_HI 7:4
`define LGFV_SLOT_OFF 4'h0
`define LGFV_SLOT_PIN_LAST 4'h7
`define LGFV_SLOT_INT 4'h8
`define LGFV_SLOT_EXT 4'h9
`define LGFV_LC_CNT 2:0
`define LGFV_LC_LEGACY 3
`define LGFV_LC_RATE 5:4
`define LGFV_RATE_10M 2'h1
`define LGFV_RATE_2M5 2'h2
`define LGFV_POL_FV 0
`define LGFV_POL_LV 1
`define LGFV_POL_FWD 2
`define LGFV_FWD_PER1 3'h1
`define LGFV_FWD_PER2 3'h2
`define LGFV_FWD_PER5 3'h5
`define LGFV_CNT_MAX 8'hFF
`define LGFV_CLK_NS 20
`define LGFV_BC_FRAME_NS_50M 600
`define LGFV_BC_FRAME_NS_10M 3000
`define LGFV_BC_FRAME_US_2M5 12
`define LGFV_AXI_OKAY 2'h0
`define LGFV_AXI_SLVERR 2'h2

`endif

// ---- src/lgfv_pkg.sv ----
/*
 Types of the link GPIO and frame qualification block.
 Assumes the link receive logic runs on the register clock.
*/
package lgfv_pkg;
	typedef struct packed {
		logic lock;
		logic pass;
		logic fwd_frame;
		logic [3:0] fwd_gpio;
		logic frame_window;
		logic line_window;
	} lgfv_rx_t;

	typedef struct packed {
		logic [3:0] bc_slot;
		logic frame_window;
		logic line_window;
	} lgfv_tx_t;

	typedef enum logic [1:0] {FQ_IDLE, FQ_SETUP, FQ_VIDEO} lgfv_fq_state_t;
endpackage

// ---- src/lgfv_top.sv ----
/*
 Link GPIO pin mapping, back channel slot sampling and raw frame/line
 qualification for two receive ports, with an AXI4-Lite register slave.
 Assumes receive-port signals are on aclk; pins and external sync are not.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lgfv_map.svh"

module lgfv_top (
	input wire logic aclk, // 50 MHz clock
	input wire logic aresetn, // Synchronous reset, low
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [9:0] s_axi_awaddr, // Write byte address
	input wire logic [2:0] s_axi_awprot, // Unused
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	output logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	input wire logic [9:0] s_axi_araddr, // Read byte address
	input wire logic [2:0] s_axi_arprot, // Unused
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	input wire lgfv_pkg::lgfv_rx_t [1:0] rx, // Per-port link status
	output lgfv_pkg::lgfv_tx_t [1:0] tx, // Per-port slots and windows
	input wire logic sensor_sync_pulse, // Internal frame sync
	input wire logic ext_sync_in, // External frame sync pin
	input wire logic [6:0] pin_in, // Pin levels
	output logic [6:0] pin_out, // Pin drive values
	output logic [6:0] pin_oe, // Pin driver enables
	output logic [6:0] pin_pulldown_en, // Pulldown enables
	output logic [6:0] pin_input_en // Input path enables
);
	localparam int BC_CYC_50M = `LGFV_BC_FRAME_NS_50M / `LGFV_CLK_NS;
	localparam int BC_CYC_10M = `LGFV_BC_FRAME_NS_10M / `LGFV_CLK_NS;
	localparam int BC_CYC_2M5 = (`LGFV_BC_FRAME_US_2M5 * 1000) / `LGFV_CLK_NS;

	function automatic logic [2:0] fwd_period(input logic [2:0] n);
		case (n)
			3'h1: fwd_period = `LGFV_FWD_PER1;
			3'h2: fwd_period = `LGFV_FWD_PER2;
			3'h3, 3'h4: fwd_period = `LGFV_FWD_PER5;
			default: fwd_period = 3'h0;
		endcase
	endfunction

	function automatic logic [9:0] bc_frame_cyc(input logic [1:0] r);
		case (r)
			`LGFV_RATE_10M: bc_frame_cyc = 10'(BC_CYC_10M);
			`LGFV_RATE_2M5: bc_frame_cyc = 10'(BC_CYC_2M5);
			default: bc_frame_cyc = 10'(BC_CYC_50M);
		endcase
	endfunction

	// Code 0 keeps a slot low, so reset sends nothing back
	function automatic logic slot_src(input logic [3:0] c, input logic [7:0] lvl,
		input logic isync);
		if (c == `LGFV_SLOT_OFF)
			slot_src = 1'b0;
		else if (c <= `LGFV_SLOT_PIN_LAST)
			slot_src = lvl[3'(c - 4'h1)];
		else if (c == `LGFV_SLOT_INT)
			slot_src = isync;
		else if (c == `LGFV_SLOT_EXT)
			slot_src = lvl[7];
		else
			slot_src = 1'b0;
	endfunction

	function automatic logic pin_src(input logic [7:0] ctl, input logic [7:0] st0,
		input logic [7:0] st1, input logic [7:0] dev);
		case (ctl[`LGFV_PC_GRP])
			`LGFV_GRP_PORT0: pin_src = st0[ctl[`LGFV_PC_SEL]];
			`LGFV_GRP_PORT1: pin_src = st1[ctl[`LGFV_PC_SEL]];
			`LGFV_GRP_DEV: pin_src = dev[ctl[`LGFV_PC_SEL]];
			default: pin_src = 1'b0;
		endcase
	endfunction

	function automatic logic idx_valid(input logic [7:0] i);
		idx_valid = (i == `LGFV_IDX_IN_DIS) || (i == `LGFV_IDX_PAGE) ||
			(i == `LGFV_IDX_STATUS) || (i == `LGFV_IDX_LEVEL) ||
			(i == `LGFV_IDX_FWD) || (i == `LGFV_IDX_LINK) ||
			(i == `LGFV_IDX_SLOT_A) || (i == `LGFV_IDX_SLOT_B) ||
			(i == `LGFV_IDX_POL) || (i == `LGFV_IDX_MIN) ||
			(i == `LGFV_IDX_PD_DIS) ||
			((i >= `LGFV_IDX_PIN0) && (i <= `LGFV_IDX_PIN_LAST));
	endfunction

	logic [7:0] in_dis, pd_dis, page;
	logic [7:0] pin_ctl [`LGFV_NPINS];
	logic [7:0] slot_a [`LGFV_NPORTS];
	logic [7:0] slot_b [`LGFV_NPORTS];
	logic [7:0] pol [`LGFV_NPORTS];
	logic [7:0] min_t [`LGFV_NPORTS];
	logic [7:0] link [`LGFV_NPORTS];
	logic [1:0] viol_sticky;

	// Bus slave
	logic aw_hold, w_hold, w_lane;
	logic [9:0] aw_addr;
	logic [7:0] w_byte;
	logic [7:0] rd_val;
	wire pg = page[0];
	wire [7:0] wr_idx = aw_addr[9:2];
	wire [7:0] rd_idx = s_axi_araddr[9:2];
	wire wr_go = aw_hold && w_hold && !s_axi_bvalid;
	wire wr_hit = idx_valid(wr_idx);
	wire wr_en = wr_go && wr_hit && w_lane;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 10'h000;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LGFV_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `LGFV_AXI_OKAY : `LGFV_AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Link side state
	logic [7:0] sy1, sy2, sy3, level;
	logic [3:0] fwd_hold [`LGFV_NPORTS], bc_slot_q [`LGFV_NPORTS];
	logic [2:0] fwd_cnt [`LGFV_NPORTS];
	logic [9:0] bc_cnt [`LGFV_NPORTS];
	lgfv_pkg::lgfv_fq_state_t fq_state [`LGFV_NPORTS];
	lgfv_pkg::lgfv_fq_state_t next_fq_state [`LGFV_NPORTS];
	logic [7:0] fq_cnt [`LGFV_NPORTS];
	logic [7:0] next_fq_cnt [`LGFV_NPORTS];
	logic [1:0] fq_drop, next_fq_drop, lv_prev, fv, lv, viol, fw_q, lw_q;

	always_comb begin
		rd_val = 8'h00;
		case (rd_idx)
			`LGFV_IDX_IN_DIS: rd_val = in_dis;
			`LGFV_IDX_PAGE: rd_val = page;
			`LGFV_IDX_STATUS: rd_val = {6'h00, viol_sticky};
			`LGFV_IDX_LEVEL: rd_val = level;
			`LGFV_IDX_FWD: rd_val = {fwd_hold[1], fwd_hold[0]};
			`LGFV_IDX_LINK: rd_val = link[pg];
			`LGFV_IDX_SLOT_A: rd_val = slot_a[pg];
			`LGFV_IDX_SLOT_B: rd_val = slot_b[pg];
			`LGFV_IDX_POL: rd_val = pol[pg];
			`LGFV_IDX_MIN: rd_val = min_t[pg];
			`LGFV_IDX_PD_DIS: rd_val = pd_dis;
			default: begin
				for (int i = 0; i < `LGFV_NPINS; i++) begin
					if (rd_idx == 8'(`LGFV_IDX_PIN0 + i))
						rd_val = pin_ctl[i];
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LGFV_AXI_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= idx_valid(rd_idx) ? `LGFV_AXI_OKAY : `LGFV_AXI_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Register file; banked registers follow the page bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_dis <= `LGFV_REG_RST;
			pd_dis <= `LGFV_REG_RST;
			page <= `LGFV_REG_RST;
			for (int i = 0; i < `LGFV_NPINS; i++)
				pin_ctl[i] <= `LGFV_REG_RST;
			for (int p = 0; p < `LGFV_NPORTS; p++) begin
				slot_a[p] <= `LGFV_REG_RST;
				slot_b[p] <= `LGFV_REG_RST;
				pol[p] <= `LGFV_REG_RST;
				link[p] <= `LGFV_REG_RST;
				min_t[p] <= `LGFV_MIN_RST;
			end
		end else if (wr_en) begin
			case (wr_idx)
				`LGFV_IDX_IN_DIS: in_dis <= w_byte;
				`LGFV_IDX_PD_DIS: pd_dis <= w_byte;
				`LGFV_IDX_PAGE: page <= w_byte;
				`LGFV_IDX_LINK: link[pg] <= w_byte;
				`LGFV_IDX_SLOT_A: slot_a[pg] <= w_byte;
				`LGFV_IDX_SLOT_B: slot_b[pg] <= w_byte;
				`LGFV_IDX_POL: pol[pg] <= w_byte;
				`LGFV_IDX_MIN: min_t[pg] <= w_byte;
				default: begin
					for (int i = 0; i < `LGFV_NPINS; i++) begin
						if (wr_idx == 8'(`LGFV_IDX_PIN0 + i))
							pin_ctl[i] <= w_byte;
					end
				end
			endcase
		end
	end

	// Write one clears; a violation in the same cycle wins
	wire [1:0] viol_clr = (wr_en && wr_idx == `LGFV_IDX_STATUS) ? w_byte[1:0] : 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			viol_sticky <= 2'h0;
		else
			viol_sticky <= (viol_sticky & ~viol_clr) | viol;
	end

	// Pin and external sync input: three stages, accept when last two agree
	wire [7:0] agree = ~(sy2 ^ sy3);
	wire [7:0] pin_sample = level & {1'b1, ~in_dis[6:0]};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy1 <= 8'h00;
			sy2 <= 8'h00;
			sy3 <= 8'h00;
			level <= 8'h00;
		end else begin
			sy1 <= {ext_sync_in, pin_in};
			sy2 <= sy1;
			sy3 <= sy2;
			level <= (agree & sy2) | (~agree & level);
		end
	end

	// Forward GPIO capture
	logic [2:0] fwd_per [`LGFV_NPORTS];
	logic [1:0] fwd_take, fwd_wrap, bc_tick;
	always_comb begin
		for (int p = 0; p < `LGFV_NPORTS; p++) begin
			fwd_per[p] = fwd_period(link[p][`LGFV_LC_CNT]);
			fwd_wrap[p] = (fwd_per[p] == 3'h0) || (fwd_cnt[p] == fwd_per[p] - 3'h1);
			fwd_take[p] = rx[p].fwd_frame && fwd_wrap[p] && (fwd_per[p] != 3'h0);
			bc_tick[p] = bc_cnt[p] == bc_frame_cyc(link[p][`LGFV_LC_RATE]) - 10'h001;
			tx[p] = {bc_slot_q[p], fw_q[p], lw_q[p]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < `LGFV_NPORTS; p++) begin
				fwd_hold[p] <= 4'h0;
				fwd_cnt[p] <= 3'h0;
				bc_cnt[p] <= 10'h000;
				bc_slot_q[p] <= 4'h0;
			end
		end else begin
			for (int p = 0; p < `LGFV_NPORTS; p++) begin
				if (rx[p].fwd_frame)
					fwd_cnt[p] <= fwd_wrap[p] ? 3'h0 : fwd_cnt[p] + 3'h1;
				if (link[p][`LGFV_LC_LEGACY])
					fwd_hold[p] <= 4'h0;
				else if (fwd_take[p])
					fwd_hold[p] <= rx[p].fwd_gpio;
				bc_cnt[p] <= bc_tick[p] ? 10'h000 : bc_cnt[p] + 10'h001;
				// Slots only change at a frame tick and hold in between
				if (bc_tick[p]) begin
					bc_slot_q[p][0] <= slot_src(slot_a[p][`LGFV_SLOT_LO], pin_sample,
						sensor_sync_pulse);
					bc_slot_q[p][1] <= slot_src(slot_a[p][`LGFV_SLOT_HI], pin_sample,
						sensor_sync_pulse);
					bc_slot_q[p][2] <= slot_src(slot_b[p][`LGFV_SLOT_LO], pin_sample,
						sensor_sync_pulse);
					bc_slot_q[p][3] <= slot_src(slot_b[p][`LGFV_SLOT_HI], pin_sample,
						sensor_sync_pulse);
				end
			end
		end
	end

	// Frame qualification; the count saturates so large minimums still pass
	always_comb begin
		for (int p = 0; p < `LGFV_NPORTS; p++) begin
			fv[p] = rx[p].frame_window ^ pol[p][`LGFV_POL_FV];
			lv[p] = rx[p].line_window ^ pol[p][`LGFV_POL_LV];
			next_fq_state[p] = fq_state[p];
			next_fq_cnt[p] = fq_cnt[p];
			next_fq_drop[p] = fq_drop[p];
			viol[p] = 1'b0;
			case (fq_state[p])
				lgfv_pkg::FQ_IDLE: begin
					next_fq_cnt[p] = {7'h00, fv[p]};
					next_fq_drop[p] = 1'b0;
					if (fv[p])
						next_fq_state[p] = lgfv_pkg::FQ_SETUP;
				end
				lgfv_pkg::FQ_SETUP: begin
					if (lv[p] && !lv_prev[p]) begin
						next_fq_state[p] = lgfv_pkg::FQ_VIDEO;
						if (fq_cnt[p] < min_t[p]) begin
							viol[p] = fv[p];
							next_fq_drop[p] = !pol[p][`LGFV_POL_FWD];
						end
					end else if (fq_cnt[p] != `LGFV_CNT_MAX) begin
						next_fq_cnt[p] = fq_cnt[p] + 8'h01;
					end
				end
				lgfv_pkg::FQ_VIDEO: begin
					if (!lv[p])
						next_fq_drop[p] = 1'b0;
				end
				default: next_fq_state[p] = lgfv_pkg::FQ_IDLE;
			endcase
			if (!fv[p]) begin
				next_fq_state[p] = lgfv_pkg::FQ_IDLE;
				next_fq_drop[p] = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fq_drop <= 2'h0;
			lv_prev <= 2'h0;
			for (int p = 0; p < `LGFV_NPORTS; p++) begin
				fq_state[p] <= lgfv_pkg::FQ_IDLE;
				fq_cnt[p] <= 8'h00;
				fw_q[p] <= 1'b0;
				lw_q[p] <= 1'b0;
			end
		end else begin
			fq_drop <= next_fq_drop;
			lv_prev <= lv;
			for (int p = 0; p < `LGFV_NPORTS; p++) begin
				fq_state[p] <= next_fq_state[p];
				fq_cnt[p] <= next_fq_cnt[p];
				fw_q[p] <= fv[p] &&
					(next_fq_state[p] == lgfv_pkg::FQ_VIDEO);
				lw_q[p] <= lv[p] && !next_fq_drop[p] &&
					(next_fq_state[p] == lgfv_pkg::FQ_VIDEO);
			end
		end
	end

	// Pin outputs
	wire [7:0] st0 = {tx[0].line_window, tx[0].frame_window, rx[0].pass, rx[0].lock,
		fwd_hold[0]};
	wire [7:0] st1 = {tx[1].line_window, tx[1].frame_window, rx[1].pass, rx[1].lock,
		fwd_hold[1]};
	wire lock_or = rx[0].lock | rx[1].lock;
	wire lock_and = rx[0].lock & rx[1].lock;
	wire pass_and = rx[0].pass & rx[1].pass;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 7'h00;
		end else begin
			for (int i = 0; i < `LGFV_NPINS; i++)
				pin_out[i] <= pin_src(pin_ctl[i], st0, st1, {3'h0, sensor_sync_pulse,
					pass_and, lock_and, lock_or, pin_ctl[i][`LGFV_PC_VAL]});
		end
	end

	always_comb begin
		for (int i = 0; i < `LGFV_NPINS; i++)
			pin_oe[i] = pin_ctl[i][`LGFV_PC_OE];
	end

	// Inverted register bits, so enabled after reset
	assign pin_input_en = ~in_dis[6:0];
	assign pin_pulldown_en = ~pd_dis[6:0];

endmodule
